//--- common/tcc_pkg.sv
// Constants and types for the 8-bit timer/counter compare core.
// Assumes a 32-bit APB register bus and a single 125 MHz system clock.
package tcc_pkg;

   // Register byte offsets
   localparam logic [7:0] TCC_OFS_CTRL_A  = 8'h00;
   localparam logic [7:0] TCC_OFS_CTRL_B  = 8'h04;
   localparam logic [7:0] TCC_OFS_COUNT   = 8'h08;
   localparam logic [7:0] TCC_OFS_CMP_A   = 8'h0c;
   localparam logic [7:0] TCC_OFS_CMP_B   = 8'h10;
   localparam logic [7:0] TCC_OFS_MASK    = 8'h14;
   localparam logic [7:0] TCC_OFS_FLAG    = 8'h18;

   // timer_control_a fields
   localparam int TCC_COM_A_LSB  = 6;
   localparam int TCC_COM_B_LSB  = 4;
   localparam int TCC_WGM_LO_LSB = 0;
   // timer_control_b fields
   localparam int TCC_FOC_A_BIT  = 7;
   localparam int TCC_FOC_B_BIT  = 6;
   localparam int TCC_WGM2_BIT   = 3;
   localparam int TCC_CS_LSB     = 0;
   // flag and mask bit positions
   localparam int TCC_IRQ_OVF    = 0;
   localparam int TCC_IRQ_CMP_A  = 1;
   localparam int TCC_IRQ_CMP_B  = 2;

   // Counter landmarks
   localparam logic [7:0] TCC_BOTTOM = 8'h00;
   localparam logic [7:0] TCC_MAX    = 8'hff;
   localparam logic [7:0] TCC_ONE    = 8'h01;

   // Waveform modes
   localparam logic [2:0] TCC_WGM_NORMAL   = 3'h0;
   localparam logic [2:0] TCC_WGM_PC_MAX   = 3'h1;
   localparam logic [2:0] TCC_WGM_CTC      = 3'h2;
   localparam logic [2:0] TCC_WGM_FAST_MAX = 3'h3;
   localparam logic [2:0] TCC_WGM_PC_A     = 3'h5;
   localparam logic [2:0] TCC_WGM_FAST_A   = 3'h7;

   // Clock select codes
   localparam logic [2:0] TCC_CS_STOP  = 3'h0;
   localparam logic [2:0] TCC_CS_DIV1  = 3'h1;
   localparam logic [2:0] TCC_CS_DIV8  = 3'h2;
   localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
   localparam logic [2:0] TCC_CS_DIV256  = 3'h4;
   localparam logic [2:0] TCC_CS_DIV1024 = 3'h5;
   localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;

   // Prescaler tap masks (tick when all masked bits are ones)
   localparam logic [9:0] TCC_TAP_8    = 10'h007;
   localparam logic [9:0] TCC_TAP_64   = 10'h03f;
   localparam logic [9:0] TCC_TAP_256  = 10'h0ff;
   localparam logic [9:0] TCC_TAP_1024 = 10'h3ff;

   // Compare output actions
   localparam logic [1:0] TCC_COM_OFF    = 2'h0;
   localparam logic [1:0] TCC_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCC_COM_CLEAR  = 2'h2;
   localparam logic [1:0] TCC_COM_SET    = 2'h3;

   // APB request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } tcc_apb_req_t;

   // APB answer carrier
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tcc_apb_rsp_t;

   // Whole block state
   typedef struct packed {
      logic [7:0]  count;
      logic [7:0]  cmp_a;
      logic [7:0]  cmp_b;
      logic [7:0]  buf_a;
      logic [7:0]  buf_b;
      logic [1:0]  com_a;
      logic [1:0]  com_b;
      logic [2:0]  wgm;
      logic [2:0]  cs;
      logic [2:0]  mask;
      logic [2:0]  flag;
      logic        down;
      logic        block;
      logic        wave_a;
      logic        wave_b;
      logic [9:0]  presc;
      logic        ext_s1;
      logic        ext_s2;
      logic        ext_s3;
      logic [31:0] prdata;
      logic        slverr;
   } tcc_state_t;

   localparam tcc_state_t TCC_STATE_RESET = '0;

endpackage : tcc_pkg

//--- hdl/tcc_core.sv
// 8-bit timer/counter with two compare units behind an APB slave.
// Assumes APB master per AMBA rules, external pin synchronous to pclk,
// and an interrupt controller that pulses irq_ack when it services a request.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Counter and two compares, 8-bit read/write
// - Requests visible as flags, each masked
// - Tick from prescaler or chosen pin edge
// - Clock select zero stops the counter
// - Counter accessible; processor write wins
// - Each tick clears, increments or decrements
// - Three-bit mode split over two controls
// - Detect bottom, max and mode top
// - Overflow flag point depends on mode
// - Continuous compare; flag on next tick
// - Flags clear on service or one-write
// - Compares double buffered in PWM only
// - Buffer copied at top or bottom
// - Compare access hits buffer or register
// - Outputs from match, mode, action bits
// - Force strobe updates output only, non-PWM
// - Counter write blocks next tick's matches
// - Output state kept across mode change
// - Action bits take effect immediately
// - Select 1 direct, 6/7 pin edges
// - Selects 2-5 divide by 8..1024
// - Mode 0 wraps, overflow at zero
// - Mode 2 clears on compare A match
module tcc_core
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire tcc_pkg::tcc_apb_req_t apb_req,
   output var  tcc_pkg::tcc_apb_rsp_t apb_rsp,
   // External count pin
   input  wire logic          external_count_pin,
   // Waveform outputs
   output logic               wave_out_a,
   output logic               wave_out_b,
   // Interrupt requests and service acknowledges
   output logic [2:0]         irq_req,
   input  wire logic [2:0]    irq_ack
);
   import tcc_pkg::*;

   tcc_state_t st_r;
   tcc_state_t st_nxt;

   // PWM modes have bit 0 of the mode set
   function automatic logic is_pwm(input logic [2:0] wgm);
      is_pwm = wgm[0];
   endfunction : is_pwm

   function automatic logic is_fast(input logic [2:0] wgm);
      is_fast = (wgm == TCC_WGM_FAST_MAX) || (wgm == TCC_WGM_FAST_A);
   endfunction : is_fast

   // Next output state of one compare unit
   function automatic logic wave_next(
      input logic [2:0] wgm,
      input logic [1:0] com,
      input logic       cur,
      input logic       match,
      input logic       bottom_ev,
      input logic       down,
      input logic       toggle_ok
   );
      logic r;
      r = cur;
      if (!is_pwm(wgm)) begin
         if (match) begin
            unique case (com)
               TCC_COM_OFF:    r = cur;
               TCC_COM_TOGGLE: r = ~cur;
               TCC_COM_CLEAR:  r = 1'b0;
               TCC_COM_SET:    r = 1'b1;
            endcase
         end
      end else if (is_fast(wgm)) begin
         unique case (com)
            TCC_COM_OFF:    r = cur;
            TCC_COM_TOGGLE: r = (match && toggle_ok) ? ~cur : cur;
            TCC_COM_CLEAR:  r = match ? 1'b0 : (bottom_ev ? 1'b1 : cur);
            TCC_COM_SET:    r = match ? 1'b1 : (bottom_ev ? 1'b0 : cur);
         endcase
      end else begin
         unique case (com)
            TCC_COM_OFF:    r = cur;
            TCC_COM_TOGGLE: r = (match && toggle_ok) ? ~cur : cur;
            TCC_COM_CLEAR:  r = match ? down : cur;
            TCC_COM_SET:    r = match ? ~down : cur;
         endcase
      end
      wave_next = r;
   endfunction : wave_next

   // Read view of one register; unmapped offsets read zero
   function automatic logic [31:0] read_word(
      input tcc_state_t s,
      input logic [7:0] addr,
      input logic       buf_on
   );
      logic [31:0] w;
      w = '0;
      unique case (addr)
         TCC_OFS_CTRL_A: begin
            w[TCC_COM_A_LSB +: 2]  = s.com_a;
            w[TCC_COM_B_LSB +: 2]  = s.com_b;
            w[TCC_WGM_LO_LSB +: 2] = s.wgm[1:0];
         end
         TCC_OFS_CTRL_B: begin
            w[TCC_WGM2_BIT]    = s.wgm[2];
            w[TCC_CS_LSB +: 3] = s.cs;
         end
         TCC_OFS_COUNT:  w[7:0] = s.count;
         TCC_OFS_CMP_A:  w[7:0] = buf_on ? s.buf_a : s.cmp_a;
         TCC_OFS_CMP_B:  w[7:0] = buf_on ? s.buf_b : s.cmp_b;
         TCC_OFS_MASK:   w[2:0] = s.mask;
         TCC_OFS_FLAG:   w[2:0] = s.flag;
         default:        w      = '0;
      endcase
      read_word = w;
   endfunction : read_word

   // Offsets that hold a register; reads and writes both refuse the rest
   function automatic logic reg_known(input logic [7:0] addr);
      reg_known = addr inside {TCC_OFS_CTRL_A, TCC_OFS_CTRL_B, TCC_OFS_COUNT, TCC_OFS_CMP_A,
                               TCC_OFS_CMP_B, TCC_OFS_MASK, TCC_OFS_FLAG};
   endfunction : reg_known

   // Set wins over clear so a coincident event is never lost
   function automatic logic [2:0] flag_next(
      input logic [2:0] cur,
      input logic [2:0] ev_set,
      input logic [2:0] ev_clr
   );
      flag_next = (cur & ~ev_clr) | ev_set;
   endfunction : flag_next

   logic       tick;
   logic [7:0] top;
   logic       at_top;
   logic       match_a;
   logic       match_b;
   logic       wr;
   logic       rd_setup;
   logic       ovf_ev;
   logic       load_ev;
   logic       bottom_ev;
   logic [2:0] set_ev;
   logic [2:0] clr_ev;
   logic       force_a;
   logic       force_b;
   logic       buffered;
   logic       at_bottom;
   logic       at_max;
   logic [1:0] cmp_eq;
   logic [7:0] cmp_val [2];

   assign cmp_val[0] = st_r.cmp_a;
   assign cmp_val[1] = st_r.cmp_b;

   // one comparator per unit, always running
   for (genvar u = 0; u < 2; u++) begin : g_cmp
      assign cmp_eq[u] = (st_r.count == cmp_val[u]);
   end

   always_comb begin
      st_nxt    = st_r;
      tick      = 1'b0;
      ovf_ev    = 1'b0;
      load_ev   = 1'b0;
      bottom_ev = 1'b0;
      set_ev    = '0;
      clr_ev    = '0;
      force_a   = 1'b0;
      force_b   = 1'b0;
      wr        = apb_req.psel && apb_req.penable && apb_req.pwrite;
      rd_setup  = apb_req.psel && !apb_req.penable;
      buffered  = is_pwm(st_r.wgm);

      // Free-running prescaler; first sync flop feeds only the second
      st_nxt.presc  = st_r.presc + 10'h001;
      st_nxt.ext_s1 = external_count_pin;
      st_nxt.ext_s2 = st_r.ext_s1;
      st_nxt.ext_s3 = st_r.ext_s2;

      unique case (st_r.cs)
         TCC_CS_STOP:     tick = 1'b0;
         TCC_CS_DIV1:     tick = 1'b1;
         TCC_CS_DIV8:     tick = &(st_r.presc | ~TCC_TAP_8);
         TCC_CS_DIV64:    tick = &(st_r.presc | ~TCC_TAP_64);
         TCC_CS_DIV256:   tick = &(st_r.presc | ~TCC_TAP_256);
         TCC_CS_DIV1024:  tick = &(st_r.presc | ~TCC_TAP_1024);
         TCC_CS_EXT_FALL: tick = st_r.ext_s3 && !st_r.ext_s2;
         TCC_CS_EXT_RISE: tick = !st_r.ext_s3 && st_r.ext_s2;
      endcase

      top = TCC_MAX;
      if ((st_r.wgm == TCC_WGM_PC_A) || (st_r.wgm == TCC_WGM_FAST_A)) begin
         top = st_r.cmp_a;
      end
      at_top    = (st_r.count == top);
      at_bottom = (st_r.count == TCC_BOTTOM);
      at_max    = (st_r.count == TCC_MAX);

      match_a = tick && !st_r.block && cmp_eq[0];
      match_b = tick && !st_r.block && cmp_eq[1];

      if (tick) begin
         st_nxt.block = 1'b0;
         if (st_r.wgm == TCC_WGM_CTC) begin
            if (cmp_eq[0]) begin
               st_nxt.count = TCC_BOTTOM;
            end else begin
               st_nxt.count = st_r.count + TCC_ONE;
            end
            ovf_ev = at_max;
         end else if (is_fast(st_r.wgm)) begin
            if (at_top) begin
               st_nxt.count = TCC_BOTTOM;
               ovf_ev       = 1'b1;
               load_ev      = 1'b1;
               bottom_ev    = 1'b1;
            end else begin
               st_nxt.count = st_r.count + TCC_ONE;
            end
         end else if (is_pwm(st_r.wgm)) begin
            if (st_r.down) begin
               if (at_bottom) begin
                  st_nxt.down  = 1'b0;
                  st_nxt.count = st_r.count + TCC_ONE;
               end else begin
                  st_nxt.count = st_r.count - TCC_ONE;
               end
               ovf_ev = (st_r.count == TCC_ONE);
            end else begin
               if (at_top) begin
                  st_nxt.down  = 1'b1;
                  st_nxt.count = st_r.count - TCC_ONE;
                  load_ev      = 1'b1;
               end else begin
                  st_nxt.count = st_r.count + TCC_ONE;
               end
            end
         end else begin
            st_nxt.count = st_r.count + TCC_ONE;
            ovf_ev       = at_max;
         end
      end

      // buffer load at top or bottom
      if (buffered && load_ev) begin
         st_nxt.cmp_a = st_r.buf_a;
         st_nxt.cmp_b = st_r.buf_b;
      end

      st_nxt.wave_a = wave_next(st_r.wgm, st_r.com_a, st_r.wave_a, match_a,
                                bottom_ev, st_r.down, st_r.wgm[2]);
      st_nxt.wave_b = wave_next(st_r.wgm, st_r.com_b, st_r.wave_b, match_b,
                                bottom_ev, st_r.down, 1'b0);

      set_ev[TCC_IRQ_OVF]   = ovf_ev;
      set_ev[TCC_IRQ_CMP_A] = match_a;
      set_ev[TCC_IRQ_CMP_B] = match_b;
      clr_ev = irq_ack & st_r.flag & st_r.mask;

      // APB read data latched in setup so access needs no wait
      if (rd_setup) begin
         st_nxt.prdata = read_word(st_r, apb_req.paddr, buffered);
         st_nxt.slverr = !reg_known(apb_req.paddr);
      end

      if (wr && reg_known(apb_req.paddr)) begin
         unique case (apb_req.paddr)
            TCC_OFS_CTRL_A: begin
               st_nxt.com_a      = apb_req.pwdata[TCC_COM_A_LSB +: 2];
               st_nxt.com_b      = apb_req.pwdata[TCC_COM_B_LSB +: 2];
               st_nxt.wgm[1:0]   = apb_req.pwdata[TCC_WGM_LO_LSB +: 2];
            end
            TCC_OFS_CTRL_B: begin
               st_nxt.wgm[2] = apb_req.pwdata[TCC_WGM2_BIT];
               st_nxt.cs     = apb_req.pwdata[TCC_CS_LSB +: 3];
               force_a       = apb_req.pwdata[TCC_FOC_A_BIT] && !is_pwm(st_r.wgm);
               force_b       = apb_req.pwdata[TCC_FOC_B_BIT] && !is_pwm(st_r.wgm);
            end
            TCC_OFS_COUNT: begin
               st_nxt.count = apb_req.pwdata[7:0];
               st_nxt.block = 1'b1;
            end
            TCC_OFS_CMP_A: begin
               st_nxt.buf_a = apb_req.pwdata[7:0];
               if (!buffered) begin
                  st_nxt.cmp_a = apb_req.pwdata[7:0];
               end
            end
            TCC_OFS_CMP_B: begin
               st_nxt.buf_b = apb_req.pwdata[7:0];
               if (!buffered) begin
                  st_nxt.cmp_b = apb_req.pwdata[7:0];
               end
            end
            TCC_OFS_MASK: st_nxt.mask = apb_req.pwdata[2:0];
            TCC_OFS_FLAG: clr_ev = clr_ev | apb_req.pwdata[2:0];
            default: ;
         endcase
      end

      // force updates output only, no flag or counter effect
      if (force_a) begin
         st_nxt.wave_a = wave_next(st_r.wgm, st_r.com_a, st_r.wave_a, 1'b1,
                                   1'b0, st_r.down, 1'b0);
      end
      if (force_b) begin
         st_nxt.wave_b = wave_next(st_r.wgm, st_r.com_b, st_r.wave_b, 1'b1,
                                   1'b0, st_r.down, 1'b0);
      end

      st_nxt.flag = flag_next(st_r.flag, set_ev, clr_ev);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= TCC_STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign irq_req        = st_r.flag & st_r.mask;
   assign wave_out_a     = st_r.wave_a;
   assign wave_out_b     = st_r.wave_b;
   assign apb_rsp.prdata  = st_r.prdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = st_r.slverr;

endmodule : tcc_core

`default_nettype wire

//--- dv/tcc_core_props.sv
// Port checker for the timer core: bus answers, reset state, request gating.
// Assumes it is bound into tcc_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tcc_core_props
   import tcc_pkg::*;
(
   // Clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // Register bus
   input wire tcc_pkg::tcc_apb_req_t apb_req,
   input wire tcc_pkg::tcc_apb_rsp_t apb_rsp,
   // Pins and requests
   input wire logic                  external_count_pin,
   input wire logic                  wave_out_a,
   input wire logic                  wave_out_b,
   input wire logic [2:0]            irq_req,
   input wire logic [2:0]            irq_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       setup;
   logic       rd_acc;
   logic       wr_acc;
   logic       mapped;
   logic [2:0] wd_low;
   assign setup  = apb_req.psel && !apb_req.penable;
   assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign wd_low = apb_req.pwdata[2:0];
   assign mapped = apb_req.paddr inside {TCC_OFS_CTRL_A, TCC_OFS_CTRL_B, TCC_OFS_COUNT,
                   TCC_OFS_CMP_A, TCC_OFS_CMP_B, TCC_OFS_MASK, TCC_OFS_FLAG};

   chk_ready_high: assert property (apb_rsp.pready)
      else $error("pready low");
   chk_reset_quiet: assert property (!$past(presetn) |-> irq_req == 3'h0 && !wave_out_a && !wave_out_b)
      else $error("outputs not zero after reset");
   chk_slverr_bad: assert property (setup && !mapped |=> apb_rsp.pslverr)
      else $error("unmapped access not refused");
   chk_slverr_good: assert property (setup && mapped |=> !apb_rsp.pslverr)
      else $error("mapped access refused");
   chk_read_width: assert property (rd_acc |-> apb_rsp.prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_force_rd0: assert property (rd_acc && apb_req.paddr == TCC_OFS_CTRL_B |-> apb_rsp.prdata[7:6] == 2'h0)
      else $error("force strobes read back");
   chk_unmapped_rd0: assert property (rd_acc && !mapped |-> apb_rsp.prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_mask_gate: assert property (wr_acc && apb_req.paddr == TCC_OFS_MASK |=> (irq_req & ~$past(wd_low)) == 3'h0)
      else $error("request passes cleared mask bit");
   chk_req_hold: assert property (!wr_acc && irq_ack == 3'h0 |=> (irq_req & $past(irq_req)) == $past(irq_req))
      else $error("request dropped without clear");

   cover property (irq_ack != 3'h0);
   cover property ($rose(wave_out_a));
   cover property (irq_req[0] && irq_req[1]);
endmodule : tcc_core_props

bind tcc_core tcc_core_props u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .external_count_pin(external_count_pin), .wave_out_a(wave_out_a),
   .wave_out_b(wave_out_b), .irq_req(irq_req), .irq_ack(irq_ack));
`default_nettype wire

//--- dv/tcc_irq_ctl.sv
// Interrupt controller model: services pending requests with one-cycle acknowledges.
// Assumes the bench enables servicing only when it wants flags cleared.
`timescale 1ns/1ps
`default_nettype none
module tcc_irq_ctl (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Request side
   input  wire logic [2:0] irq_req,
   input  wire logic       service_en,
   // Acknowledge pulses
   output logic [2:0]      irq_ack
);
   // service clears flag
   // A gap cycle after each pulse lets the flag fall before a new service
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ack <= 3'h0;
      end else begin
         irq_ack <= (service_en && irq_ack == 3'h0) ? irq_req : 3'h0;
      end
   end
endmodule : tcc_irq_ctl
`default_nettype wire

//--- dv/test_timer8_counter_compare_core.sv
// Self-checking bench for the timer core over APB, count pin and requests.
// Assumes tcc_core, its bound checker and the interrupt controller model.
`timescale 1ns/1ps
`default_nettype none
module test_timer8_counter_compare_core;
   import tcc_pkg::*;
   logic         pclk;
   logic         presetn;
   logic         pin;
   logic         svc;
   logic [2:0]   irq_req;
   logic [2:0]   irq_ack;
   logic         wave_a;
   logic         wave_b;
   logic [31:0]  q;
   int           num_errors;
   int           num_checks;
   tcc_apb_req_t req;
   tcc_apb_rsp_t rsp;

   tcc_core dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .external_count_pin(pin), .wave_out_a(wave_a), .wave_out_b(wave_b),
      .irq_req(irq_req), .irq_ack(irq_ack));
   tcc_irq_ctl u_ctl (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
      .service_en(svc), .irq_ack(irq_ack));

   always #4 pclk = ~pclk;

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Setup then access, held until pready is sampled high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rd(input string name, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(name, e, q);
   endtask : rd

   task outs(input logic [2:0] ei, input logic ew);
      @(negedge pclk);
      check("irq_req", {29'h0, ei}, {29'h0, irq_req});
      check("wave_out_a", {31'h0, ew}, {31'h0, wave_a});
   endtask : outs

   // Pin high then low, long enough for the synchroniser
   task pulse;
      @(posedge pclk);
      pin <= 1'b1;
      repeat (6) @(posedge pclk);
      pin <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : pulse

   task t_regs;
      for (int a = 0; a <= 8'h1c; a += 4) begin
         rd("reset", 8'(a), 32'h0);
      end
      wr(TCC_OFS_COUNT, 32'h1a5);
      rd("count", TCC_OFS_COUNT, 32'ha5);
      wr(TCC_OFS_CMP_A, 32'h5a);
      rd("cmp_a", TCC_OFS_CMP_A, 32'h5a);
      wr(TCC_OFS_CMP_B, 32'hc3);
      rd("cmp_b", TCC_OFS_CMP_B, 32'hc3);
      wr(TCC_OFS_CTRL_A, 32'hf2);
      rd("ctrl_a", TCC_OFS_CTRL_A, 32'hf2);
      wr(TCC_OFS_CTRL_B, 32'hc8);
      rd("ctrl_b", TCC_OFS_CTRL_B, 32'h08);
      outs(3'h0, 1'b1);
      check("wave_out_b", 32'h1, {31'h0, wave_b});
      // force strobes preset both outputs low
      wr(TCC_OFS_CTRL_A, 32'ha0);
      wr(TCC_OFS_CTRL_B, 32'hc0);
      @(negedge pclk);
      check("wave_out_b", 32'h0, {31'h0, wave_b});
      wr(TCC_OFS_CTRL_A, 32'h0);
      wr(TCC_OFS_MASK, 32'hff);
      rd("mask", TCC_OFS_MASK, 32'h7);
      wr(TCC_OFS_COUNT, 32'h33);
      repeat (40) @(posedge pclk);
      rd("stopped", TCC_OFS_COUNT, 32'h33);
   endtask : t_regs

   task t_ext;
      wr(TCC_OFS_CMP_A, 32'h3);
      wr(TCC_OFS_CMP_B, 32'h5);
      wr(TCC_OFS_COUNT, 32'h2);
      wr(TCC_OFS_CTRL_B, {29'h0, TCC_CS_EXT_RISE});
      pulse();
      rd("tick1", TCC_OFS_COUNT, 32'h3);
      pulse();
      rd("tick2", TCC_OFS_COUNT, 32'h4);
      outs(3'h2, 1'b0);
      wr(TCC_OFS_COUNT, 32'h5);
      pulse();
      outs(3'h2, 1'b0);
      wr(TCC_OFS_CTRL_B, {29'h0, TCC_CS_EXT_FALL});
      pulse();
      rd("fall", TCC_OFS_COUNT, 32'h7);
      wr(TCC_OFS_COUNT, 32'hff);
      pulse();
      rd("wrap", TCC_OFS_COUNT, 32'h0);
      outs(3'h3, 1'b0);
      wr(TCC_OFS_FLAG, 32'h2);
      outs(3'h1, 1'b0);
      @(posedge pclk);
      svc <= 1'b1;
      repeat (4) @(posedge pclk);
      svc <= 1'b0;
      outs(3'h0, 1'b0);
   endtask : t_ext

   task t_ctc;
      wr(TCC_OFS_CTRL_A, {29'h0, TCC_WGM_CTC});
      wr(TCC_OFS_CMP_A, 32'h2);
      wr(TCC_OFS_COUNT, 32'h0);
      repeat (3) pulse();
      rd("ctc", TCC_OFS_COUNT, 32'h0);
      wr(TCC_OFS_FLAG, 32'h7);
      wr(TCC_OFS_CTRL_B, 32'h0);
   endtask : t_ctc

   task t_force;
      wr(TCC_OFS_CTRL_A, 32'h40);
      wr(TCC_OFS_CTRL_B, 32'h80);
      outs(3'h0, 1'b1);
      wr(TCC_OFS_CTRL_A, {30'h0, TCC_WGM_FAST_MAX[1:0]} | 32'h40);
      wr(TCC_OFS_CTRL_B, 32'h80);
      outs(3'h0, 1'b1);
      wr(TCC_OFS_CTRL_A, 32'h80);
      wr(TCC_OFS_CTRL_B, 32'h80);
      outs(3'h0, 1'b0);
   endtask : t_force

   task t_buf;
      wr(TCC_OFS_CTRL_A, 32'h0);
      wr(TCC_OFS_CMP_A, 32'h11);
      wr(TCC_OFS_CTRL_A, {30'h0, TCC_WGM_FAST_MAX[1:0]});
      wr(TCC_OFS_CMP_A, 32'h40);
      rd("buffer", TCC_OFS_CMP_A, 32'h40);
      wr(TCC_OFS_CTRL_A, 32'h0);
      rd("active", TCC_OFS_CMP_A, 32'h11);
      wr(TCC_OFS_CTRL_A, {30'h0, TCC_WGM_FAST_MAX[1:0]});
      wr(TCC_OFS_COUNT, 32'hff);
      wr(TCC_OFS_CTRL_B, {29'h0, TCC_CS_DIV1});
      wr(TCC_OFS_CTRL_B, 32'h0);
      wr(TCC_OFS_CTRL_A, 32'h0);
      rd("loaded", TCC_OFS_CMP_A, 32'h40);
   endtask : t_buf

   // Free-running prescaler: allow one tick of phase slack, four for the undivided select
   task t_presc;
      int div [5] = '{1, 8, 64, 256, 1024};
      for (int i = 0; i < 5; i++) begin
         wr(TCC_OFS_COUNT, 32'h0);
         wr(TCC_OFS_CTRL_B, 32'(i + 1));
         repeat (4 * div[i]) @(posedge pclk);
         wr(TCC_OFS_CTRL_B, 32'h0);
         xfer(1'b0, TCC_OFS_COUNT, 32'h0);
         check("presc_low", 32'h1, {31'h0, q >= 32'd4});
         check("presc_high", 32'h1, {31'h0, q <= (i == 0 ? 32'd8 : 32'd5)});
      end
   endtask : t_presc

   task results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      results();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      pin = 1'b0;
      svc = 1'b0;
      req = '0;
      num_errors = 0;
      num_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ext();
      t_ctc();
      t_force();
      t_buf();
      t_presc();
      results();
   end
endmodule : test_timer8_counter_compare_core
`default_nettype wire
